//--- include/lib_pkg.sv
package lib_pkg;
	// clock rate used to turn bus timings into cycle counts
	localparam int CLK_MHZ = 20;
	// register byte offsets on the Avalon slave
	localparam logic [4:0] REG_CTRL = 5'h00;
	localparam logic [4:0] REG_COM0 = 5'h04;
	localparam logic [4:0] REG_COM1 = 5'h08;
	localparam logic [4:0] REG_IRQEN = 5'h0c;
	localparam logic [4:0] REG_STAT = 5'h10;
	// control fields and reset values
	localparam int CTRL_COM0_BIT = 0;
	localparam int CTRL_COM1_BIT = 1;
	localparam int CTRL_MEMW_BIT = 2;
	localparam logic [2:0] CTRL_RST = 3'h3;
	localparam logic [11:0] COM0_RST = 12'h3f8;
	localparam logic [11:0] COM1_RST = 12'h2f8;
	localparam int NUM_IRQ = 10;
	localparam logic [NUM_IRQ-1:0] IRQEN_RST = 10'h000;
	localparam int STAT_BUSY_BIT = 16;
	localparam int STAT_W16_BIT = 17;
	// address ranges kept off or allowed onto the expansion bus
	localparam logic [19:0] OWN_LO = 20'h0_0c80;
	localparam logic [19:0] OWN_HI = 20'h0_0cbf;
	localparam logic [19:0] MEMW_LO = 20'hd_0000;
	localparam logic [19:0] MEMW_HI = 20'hd_ffff;
	localparam int NUM_DACK = 7;
	// bus cycle timing
	localparam int T_ADDR_NS = 150;
	localparam int T_CMD8_NS = 500;
	localparam int T_CMD16_NS = 200;
	localparam int T_REC_NS = 150;
	localparam int T_RDY_MAX_NS = 15600;
	localparam logic [7:0] ADDR_CYC = 8'((T_ADDR_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0] CMD8_CYC = 8'((T_CMD8_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0] CMD16_CYC = 8'((T_CMD16_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0] REC_CYC = 8'((T_REC_NS * CLK_MHZ + 999) / 1000);
	localparam logic [9:0] RDY_MAX_CYC = 10'(T_RDY_MAX_NS * CLK_MHZ / 1000);
endpackage

//--- include/lib_cyc_if.sv
`timescale 1ns/1ps
interface lib_cyc_if;
	logic start;
	logic is_mem;
	logic write;
	logic wide;
	logic [19:0] addr;
	logic [15:0] wdata;
	logic done;
	logic was16;
	logic [15:0] rdata;
	modport ctl(output start, is_mem, write, wide, addr, wdata, input done, was16, rdata);
	modport eng(input start, is_mem, write, wide, addr, wdata, output done, was16, rdata);
endinterface

//--- src/lib_isa_engine.sv
`timescale 1ns/1ps
module lib_isa_engine (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_arst_n,
	// cycle request
	lib_cyc_if.eng cyc,
	// synchronised bus inputs
	input wire logic i_iocs16_n,
	input wire logic i_iochrdy,
	input wire logic [15:0] i_sd,
	// bus outputs
	output logic [19:0] o_sa,
	output logic o_sbhe_n,
	output logic o_bale,
	output logic o_ior_n,
	output logic o_iow_n,
	output logic o_memr_n,
	output logic o_memw_n,
	output logic [15:0] o_sd,
	output logic o_sd_oe
);
	import lib_pkg::*;
	typedef enum logic [1:0] {E_IDLE, E_ADDR, E_CMD, E_REC} lib_eng_st_t;
	lib_eng_st_t st_reg;
	logic [7:0] cnt_reg;
	logic [9:0] rdy_reg;
	logic hi_reg, w16_reg, mem_reg, wr_reg, wide_reg;
	logic [15:0] wdat_reg;
	logic go16;

	// iocs16 needs two cycles through the synchroniser before it is trusted
	if (ADDR_CYC < 8'h03) begin : g_chk
		$error("address phase too short for the iocs16 synchroniser");
	end

	assign go16 = wide_reg && !mem_reg && !hi_reg && !i_iocs16_n;

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			st_reg <= E_IDLE;
			cnt_reg <= 8'h00;
			rdy_reg <= 10'h000;
			{hi_reg, w16_reg, mem_reg, wr_reg, wide_reg} <= 5'h00;
			wdat_reg <= 16'h0000;
			o_sa <= 20'h0_0000;
			{o_sbhe_n, o_ior_n, o_iow_n, o_memr_n, o_memw_n} <= 5'h1f;
			o_bale <= 1'b0;
			o_sd <= 16'h0000;
			o_sd_oe <= 1'b0;
			cyc.done <= 1'b0;
			cyc.was16 <= 1'b0;
			cyc.rdata <= 16'hffff;
		end else begin
			cyc.done <= 1'b0;
			case (st_reg)
			E_IDLE: begin
				if (cyc.start) begin
					st_reg <= E_ADDR;
					cnt_reg <= ADDR_CYC - 8'h01;
					o_sa <= cyc.addr;
					o_sbhe_n <= !(cyc.wide && !cyc.is_mem);
					o_bale <= 1'b1;
					o_sd <= cyc.wdata;
					o_sd_oe <= cyc.write;
					{mem_reg, wr_reg, wide_reg} <= {cyc.is_mem, cyc.write, cyc.wide};
					{hi_reg, w16_reg} <= 2'h0;
					wdat_reg <= cyc.wdata;
					cyc.rdata <= 16'hffff;
				end
			end
			E_ADDR: begin
				o_bale <= 1'b0;
				if (cnt_reg != 8'h00) begin
					cnt_reg <= cnt_reg - 8'h01;
				end else begin
					w16_reg <= go16;
					o_ior_n <= !(!mem_reg && !wr_reg);
					o_iow_n <= !(!mem_reg && wr_reg);
					o_memr_n <= !(mem_reg && !wr_reg);
					o_memw_n <= !(mem_reg && wr_reg);
					cnt_reg <= go16 ? CMD16_CYC - 8'h01 : CMD8_CYC - 8'h01;
					rdy_reg <= 10'h000;
					st_reg <= E_CMD;
				end
			end
			E_CMD: begin
				if (cnt_reg != 8'h00) begin
					cnt_reg <= cnt_reg - 8'h01;
				end else if (i_iochrdy || rdy_reg == RDY_MAX_CYC) begin
					// a stuck ready line is cut off rather than hanging the host
					{o_ior_n, o_iow_n, o_memr_n, o_memw_n} <= 4'hf;
					if (w16_reg) begin
						cyc.rdata <= i_sd;
					end else if (hi_reg) begin
						cyc.rdata[15:8] <= i_sd[7:0];
					end else begin
						cyc.rdata[7:0] <= i_sd[7:0];
					end
					cnt_reg <= REC_CYC - 8'h01;
					st_reg <= E_REC;
				end else begin
					rdy_reg <= rdy_reg + 10'h001;
				end
			end
			E_REC: begin
				if (cnt_reg != 8'h00) begin
					cnt_reg <= cnt_reg - 8'h01;
				end else if (wide_reg && !w16_reg && !hi_reg) begin
					// 8-bit module: upper byte follows as its own cycle
					hi_reg <= 1'b1;
					o_sa <= o_sa + 20'h0_0001;
					o_sbhe_n <= 1'b1;
					o_bale <= 1'b1;
					o_sd <= {wdat_reg[15:8], wdat_reg[15:8]};
					cnt_reg <= ADDR_CYC - 8'h01;
					st_reg <= E_ADDR;
				end else begin
					cyc.done <= 1'b1;
					cyc.was16 <= w16_reg;
					o_sd_oe <= 1'b0;
					st_reg <= E_IDLE;
				end
			end
			default: st_reg <= E_IDLE;
			endcase
		end
	end

	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_arst_n);

	property p_one_strobe;
		$onehot0({~o_ior_n, ~o_iow_n, ~o_memr_n, ~o_memw_n});
	endproperty
	a_one_strobe: assert property (p_one_strobe) else $error("two command strobes at once");
	property p_w16_cap;
		(st_reg == E_CMD && w16_reg) |-> (wide_reg && !mem_reg && !hi_reg);
	endproperty
	a_w16_cap: assert property (p_w16_cap) else $error("16-bit cycle without request");
	property p_ior_min;
		$fell(o_ior_n) |=> !o_ior_n [*3];
	endproperty
	a_ior_min: assert property (p_ior_min) else $error("read strobe too short");
	property p_bale;
		o_bale |=> !o_bale && o_ior_n && o_iow_n && o_memr_n && o_memw_n;
	endproperty
	a_bale: assert property (p_bale) else $error("address latch pulse malformed");
endmodule

//--- src/lib_bridge.sv
// Local design decisions: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// Summary of operation
// - bridge is the only expansion bus master; external mastering is not offered.
// - refresh output held inactive high forever.
// - all seven DMA acknowledges held high; DMA requests not taken.
// - terminal count output held low forever.
// - 8-bit and 16-bit I/O cycles; 16-bit only when module signals it.
// - forward only when nothing on the host side claims the address.
// - I/O 0xC80-0xCBF is internal and never forwarded.
// - serial ports default enabled at 0x3F8 and 0x2F8, withheld while enabled.
// - each enabled serial port withholds one 8-byte range at its base.
// - memory window 0xD0000-0xDFFFF forwarded only when enabled.
// - only IRQ3-7, IRQ9-12 and IRQ15 routed to host.
// - every interrupt line disabled at reset until enabled individually.
// - one module per interrupt line; lines are never merged.
module lib_bridge (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_arst_n,
	// Avalon-MM register slave
	input wire logic [4:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	// decoded host cycles
	input wire logic i_host_req,
	input wire logic i_host_is_mem,
	input wire logic i_host_write,
	input wire logic i_host_wide,
	input wire logic [19:0] i_host_addr,
	input wire logic [15:0] i_host_wdata,
	input wire logic i_host_ext_claim,
	output logic o_host_done,
	output logic o_host_fwd,
	output logic [15:0] o_host_rdata,
	output logic [lib_pkg::NUM_IRQ-1:0] o_host_irq,
	// expansion bus
	output logic [19:0] o_isa_sa,
	output logic o_isa_sbhe_n,
	output logic o_isa_bale,
	output logic o_isa_aen,
	output logic o_isa_ior_n,
	output logic o_isa_iow_n,
	output logic o_isa_memr_n,
	output logic o_isa_memw_n,
	input wire logic [15:0] i_isa_sd,
	output logic [15:0] o_isa_sd,
	output logic o_isa_sd_oe,
	input wire logic i_isa_iocs16_n,
	input wire logic i_isa_iochrdy,
	input wire logic [lib_pkg::NUM_IRQ-1:0] i_isa_irq,
	output logic o_isa_refresh_n,
	output logic [lib_pkg::NUM_DACK-1:0] o_isa_dack_n,
	output logic o_isa_tc
);
	import lib_pkg::*;

	typedef enum logic {H_IDLE, H_ISA} lib_host_st_t;
	localparam int SYNC_W = NUM_IRQ + 18;
	localparam logic [SYNC_W-1:0] SYNC_RST = {2'h3, 16'h0000, IRQEN_RST};

	lib_cyc_if cyc();

	logic [SYNC_W-1:0] sync_a_reg, sync_b_reg;
	logic [NUM_IRQ-1:0] s_irq;
	logic [15:0] s_sd;
	logic s_rdy, s_cs16_n;
	logic wait_reg;
	logic [31:0] rd_mux;
	logic [2:0] ctrl_reg;
	logic [8:0] com0_reg, com1_reg;
	logic [NUM_IRQ-1:0] irqen_reg;
	lib_host_st_t h_st_reg;
	logic own_hit, com0_hit, com1_hit, mem_hit, fwd_hit, accept;

	// all bus inputs cross two flops before anything looks at them
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			sync_a_reg <= SYNC_RST;
			sync_b_reg <= SYNC_RST;
		end else begin
			sync_a_reg <= {i_isa_iocs16_n, i_isa_iochrdy, i_isa_sd, i_isa_irq};
			sync_b_reg <= sync_a_reg;
		end
	end
	assign s_irq = sync_b_reg[NUM_IRQ-1:0];
	assign s_sd = sync_b_reg[NUM_IRQ+:16];
	assign s_rdy = sync_b_reg[NUM_IRQ+16];
	assign s_cs16_n = sync_b_reg[NUM_IRQ+17];

	// pins that this bridge never uses for their original purpose
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_isa_aen <= 1'b0;
			o_isa_refresh_n <= 1'b1;
			o_isa_dack_n <= 7'h7f;
			o_isa_tc <= 1'b0;
		end else begin
			o_isa_aen <= 1'b0;
			o_isa_refresh_n <= 1'b1;
			o_isa_dack_n <= 7'h7f;
			o_isa_tc <= 1'b0;
		end
	end

	// one wait cycle on every access keeps read data registered
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			wait_reg <= 1'b1;
			o_avs_readdata <= 32'h0000_0000;
		end else if (!wait_reg) begin
			wait_reg <= 1'b1;
		end else if (i_avs_read || i_avs_write) begin
			wait_reg <= 1'b0;
			if (i_avs_read) begin
				o_avs_readdata <= rd_mux;
			end
		end
	end
	assign o_avs_waitrequest = wait_reg;

	always_comb begin
		rd_mux = 32'h0000_0000;
		case (i_avs_address)
		REG_CTRL: rd_mux[2:0] = ctrl_reg;
		REG_COM0: rd_mux[11:0] = {com0_reg, 3'h0};
		REG_COM1: rd_mux[11:0] = {com1_reg, 3'h0};
		REG_IRQEN: rd_mux[NUM_IRQ-1:0] = irqen_reg;
		REG_STAT: begin
			rd_mux[NUM_IRQ-1:0] = s_irq;
			rd_mux[STAT_BUSY_BIT] = (h_st_reg != H_IDLE);
			rd_mux[STAT_W16_BIT] = cyc.was16;
		end
		default: rd_mux = 32'h0000_0000;
		endcase
	end

	// writes land on the edge where waitrequest is seen low
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ctrl_reg <= CTRL_RST;
			com0_reg <= COM0_RST[11:3];
			com1_reg <= COM1_RST[11:3];
			irqen_reg <= IRQEN_RST;
		end else if (i_avs_write && !wait_reg) begin
			case (i_avs_address)
			REG_CTRL: begin
				if (i_avs_byteenable[0]) begin
					ctrl_reg <= i_avs_writedata[2:0];
				end
			end
			REG_COM0: begin
				if (i_avs_byteenable[0]) begin
					com0_reg[4:0] <= i_avs_writedata[7:3];
				end
				if (i_avs_byteenable[1]) begin
					com0_reg[8:5] <= i_avs_writedata[11:8];
				end
			end
			REG_COM1: begin
				if (i_avs_byteenable[0]) begin
					com1_reg[4:0] <= i_avs_writedata[7:3];
				end
				if (i_avs_byteenable[1]) begin
					com1_reg[8:5] <= i_avs_writedata[11:8];
				end
			end
			REG_IRQEN: begin
				if (i_avs_byteenable[0]) begin
					irqen_reg[7:0] <= i_avs_writedata[7:0];
				end
				if (i_avs_byteenable[1]) begin
					irqen_reg[9:8] <= i_avs_writedata[9:8];
				end
			end
			default: ctrl_reg <= ctrl_reg;
			endcase
		end
	end

	// address decode of the pending host cycle
	assign own_hit = !i_host_is_mem && i_host_addr >= OWN_LO && i_host_addr <= OWN_HI;
	assign com0_hit = !i_host_is_mem && ctrl_reg[CTRL_COM0_BIT]
		&& i_host_addr[19:3] == {8'h00, com0_reg};
	assign com1_hit = !i_host_is_mem && ctrl_reg[CTRL_COM1_BIT]
		&& i_host_addr[19:3] == {8'h00, com1_reg};
	assign mem_hit = ctrl_reg[CTRL_MEMW_BIT]
		&& i_host_addr >= MEMW_LO && i_host_addr <= MEMW_HI;
	assign fwd_hit = !i_host_ext_claim
		&& (i_host_is_mem ? mem_hit : !(own_hit || com0_hit || com1_hit));
	assign accept = (h_st_reg == H_IDLE) && i_host_req && !o_host_done;

	// host cycle sequencing: forward or complete at once as not ours
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			h_st_reg <= H_IDLE;
			cyc.start <= 1'b0;
			cyc.is_mem <= 1'b0;
			cyc.write <= 1'b0;
			cyc.wide <= 1'b0;
			cyc.addr <= 20'h0_0000;
			cyc.wdata <= 16'h0000;
			o_host_done <= 1'b0;
			o_host_fwd <= 1'b0;
			o_host_rdata <= 16'hffff;
		end else begin
			cyc.start <= 1'b0;
			o_host_done <= 1'b0;
			case (h_st_reg)
			H_IDLE: begin
				if (accept && fwd_hit) begin
					cyc.start <= 1'b1;
					cyc.is_mem <= i_host_is_mem;
					cyc.write <= i_host_write;
					// memory cycles always run as bytes
					cyc.wide <= i_host_wide && !i_host_is_mem;
					cyc.addr <= i_host_addr;
					cyc.wdata <= i_host_wdata;
					h_st_reg <= H_ISA;
				end else if (accept) begin
					// left for the owner on the host side to answer
					o_host_done <= 1'b1;
					o_host_fwd <= 1'b0;
					o_host_rdata <= 16'hffff;
				end
			end
			H_ISA: begin
				if (cyc.done) begin
					o_host_done <= 1'b1;
					o_host_fwd <= 1'b1;
					o_host_rdata <= cyc.rdata;
					h_st_reg <= H_IDLE;
				end
			end
			default: h_st_reg <= H_IDLE;
			endcase
		end
	end

	// each line passes alone through its own enable, no merging
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_host_irq <= IRQEN_RST;
		end else begin
			o_host_irq <= s_irq & irqen_reg;
		end
	end

	lib_isa_engine u_engine (
		.i_clock(i_clock),
		.i_arst_n(i_arst_n),
		.cyc(cyc.eng),
		.i_iocs16_n(s_cs16_n),
		.i_iochrdy(s_rdy),
		.i_sd(s_sd),
		.o_sa(o_isa_sa),
		.o_sbhe_n(o_isa_sbhe_n),
		.o_bale(o_isa_bale),
		.o_ior_n(o_isa_ior_n),
		.o_iow_n(o_isa_iow_n),
		.o_memr_n(o_isa_memr_n),
		.o_memw_n(o_isa_memw_n),
		.o_sd(o_isa_sd),
		.o_sd_oe(o_isa_sd_oe)
	);

	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_arst_n);

	property p_static_pins;
		o_isa_refresh_n && !o_isa_aen;
	endproperty
	a_static_pins: assert property (p_static_pins) else $error("refresh or aen driven");
	property p_dack;
		(&o_isa_dack_n) && !o_isa_tc;
	endproperty
	a_dack: assert property (p_dack) else $error("dma pins active");
	property p_ext;
		cyc.start |-> !$past(i_host_ext_claim);
	endproperty
	a_ext: assert property (p_ext) else $error("claimed cycle forwarded");
	property p_own;
		cyc.start |-> !$past(own_hit) && cyc.addr != OWN_LO;
	endproperty
	a_own: assert property (p_own) else $error("internal range forwarded");
	property p_com;
		cyc.start |-> !$past(com0_hit || com1_hit);
	endproperty
	a_com: assert property (p_com) else $error("serial port range forwarded");
	property p_mem;
		cyc.start && cyc.is_mem |-> $past(ctrl_reg[CTRL_MEMW_BIT]) && cyc.addr >= MEMW_LO;
	endproperty
	a_mem: assert property (p_mem) else $error("memory cycle outside window");
	property p_irq_off;
		irqen_reg == 10'h000 [*2] |-> o_host_irq == 10'h000;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("disabled line reached host");
	property p_irq_pass;
		irqen_reg[0] && s_irq[0] |=> o_host_irq[0];
	endproperty
	a_irq_pass: assert property (p_irq_pass) else $error("enabled line not passed");
	property p_done;
		(h_st_reg == H_ISA && cyc.done) |=> o_host_done && o_host_fwd
			&& o_host_rdata == $past(cyc.rdata);
	endproperty
	a_done: assert property (p_done) else $error("read data not returned");
	property p_reject;
		accept && !fwd_hit |=> o_host_done && !o_host_fwd && !cyc.start;
	endproperty
	a_reject: assert property (p_reject) else $error("unforwarded cycle not closed");

	c_io_read: cover property (cyc.start && !cyc.is_mem && !cyc.write);
	c_mem_write: cover property (cyc.start && cyc.is_mem && cyc.write);
	c_claimed: cover property (accept && own_hit);
	c_wide16: cover property (cyc.done && cyc.was16);
endmodule

//--- testbench/lib_isa_module.sv
`timescale 1ns/1ps
module lib_isa_module (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_arst_n,
	// behaviour set by the bench
	input wire logic i_wide_en,
	input wire logic [2:0] i_waits,
	// expansion bus from the bridge
	input wire logic [19:0] i_sa,
	input wire logic i_sbhe_n,
	input wire logic i_ior_n,
	input wire logic i_iow_n,
	input wire logic i_memr_n,
	input wire logic i_memw_n,
	input wire logic [15:0] i_sd,
	input wire logic i_sd_oe,
	// resolved data wire and module answers
	output logic [15:0] o_sd,
	output logic o_iocs16_n,
	output logic o_iochrdy
);
	logic [7:0] mem_reg [256];
	logic [15:0] last_reg;
	logic [2:0] wait_reg;
	logic io_hit, mem_hit, rd, wr;
	logic [7:0] a;
	logic [7:0] a1;
	assign a = i_sa[7:0];
	assign a1 = a + 8'h01;
	assign io_hit = i_sa[19:8] == 12'h003;
	assign mem_hit = i_sa[19:8] == 12'hd00;
	assign rd = (io_hit && !i_ior_n) || (mem_hit && !i_memr_n);
	assign wr = (io_hit && !i_iow_n) || (mem_hit && !i_memw_n);
	// wide claim only for its own I/O decode
	assign o_iocs16_n = !(io_hit && i_wide_en);
	// no master or DMA request pins exist on this model
	assign o_iochrdy = !((rd || wr) && wait_reg < i_waits);
	// undriven wire flips, so a stale value never passes for data
	always_comb begin
		if (i_sd_oe)
			o_sd = i_sd;
		else if (rd)
			o_sd = {o_iocs16_n ? ~last_reg[15:8] : mem_reg[a1], mem_reg[a]};
		else
			o_sd = ~last_reg;
	end
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			last_reg <= '0;
			wait_reg <= '0;
			for (int i = 0; i < 256; i++)
				mem_reg[i] <= ~8'(i);
		end else begin
			last_reg <= o_sd;
			wait_reg <= (rd || wr) ? wait_reg + {2'b0, wait_reg != 3'h7} : 3'h0;
			if (wr && i_sd_oe) begin
				mem_reg[a] <= i_sd[7:0];
				if (!o_iocs16_n && !i_sbhe_n)
					mem_reg[a1] <= i_sd[15:8];
			end
		end
	end
endmodule

//--- testbench/lib_bridge_test.sv
`timescale 1ns/1ps
module lib_bridge_test;
	import lib_pkg::*;
	logic i_clock = 1'b0;
	logic i_arst_n = 1'b0;
	logic [4:0] av_addr = '0;
	logic av_rd = 1'b0, av_wr = 1'b0, av_wait;
	logic [31:0] av_wdata = '0, av_rdata;
	logic [3:0] av_be = '0;
	logic h_req = 1'b0, h_mem = 1'b0, h_wr = 1'b0, h_wide = 1'b0, h_claim = 1'b0;
	logic [19:0] h_addr = '0, sa;
	logic [15:0] h_wdata = '0, h_rdata, sd_out, sd_wire;
	logic h_done, h_fwd, bale, aen, sbhe_n, ior_n, iow_n, memr_n, memw_n, sd_oe, ref_n, tc;
	logic iocs16_n, iochrdy;
	logic [NUM_IRQ-1:0] h_irq;
	logic [NUM_IRQ-1:0] irq_pin = '0;
	logic [NUM_DACK-1:0] dack_n;
	logic we = 1'b0;
	logic [2:0] waits = '0;
	logic [2:0] ctrl_m = CTRL_RST;
	logic [11:0] com0_m = COM0_RST, com1_m = COM1_RST;
	logic [7:0] ref_mem [256];
	logic stb_prev = 1'b1;
	int nstb = 0, bad_count = 0, check_count = 0, cyc = 0, seed = 71;
	always #25 i_clock = ~i_clock;
	lib_bridge lib_bridge_inst (.i_clock(i_clock), .i_arst_n(i_arst_n),
		.i_avs_address(av_addr), .i_avs_read(av_rd), .i_avs_write(av_wr),
		.i_avs_writedata(av_wdata), .i_avs_byteenable(av_be), .o_avs_readdata(av_rdata),
		.o_avs_waitrequest(av_wait), .i_host_req(h_req), .i_host_is_mem(h_mem),
		.i_host_write(h_wr), .i_host_wide(h_wide), .i_host_addr(h_addr),
		.i_host_wdata(h_wdata), .i_host_ext_claim(h_claim), .o_host_done(h_done),
		.o_host_fwd(h_fwd), .o_host_rdata(h_rdata), .o_host_irq(h_irq), .o_isa_sa(sa),
		.o_isa_sbhe_n(sbhe_n), .o_isa_bale(bale), .o_isa_aen(aen), .o_isa_ior_n(ior_n),
		.o_isa_iow_n(iow_n), .o_isa_memr_n(memr_n), .o_isa_memw_n(memw_n),
		.i_isa_sd(sd_wire), .o_isa_sd(sd_out), .o_isa_sd_oe(sd_oe),
		.i_isa_iocs16_n(iocs16_n), .i_isa_iochrdy(iochrdy), .i_isa_irq(irq_pin),
		.o_isa_refresh_n(ref_n), .o_isa_dack_n(dack_n), .o_isa_tc(tc));
	lib_isa_module lib_isa_module_inst (.i_clock(i_clock), .i_arst_n(i_arst_n),
		.i_wide_en(we), .i_waits(waits), .i_sa(sa), .i_sbhe_n(sbhe_n), .i_ior_n(ior_n),
		.i_iow_n(iow_n), .i_memr_n(memr_n), .i_memw_n(memw_n), .i_sd(sd_out),
		.i_sd_oe(sd_oe), .o_sd(sd_wire), .o_iocs16_n(iocs16_n), .o_iochrdy(iochrdy));
	task automatic finish_test;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// strobe falls are counted so withheld cycles must leave the bus quiet
	always @(posedge i_clock) begin
		stb_prev <= ior_n & iow_n & memr_n & memw_n;
		if (stb_prev && !(ior_n & iow_n & memr_n & memw_n))
			nstb <= nstb + 1;
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			bad_count++;
			finish_test();
		end
	end
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (e !== g) begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic bus_op(input logic w, input logic [4:0] a, input logic [31:0] d,
			output logic [31:0] r);
		@(posedge i_clock);
		av_addr <= a;
		av_wdata <= d;
		av_be <= 4'hf;
		av_rd <= !w;
		av_wr <= w;
		do @(posedge i_clock); while (av_wait !== 1'b0);
		r = av_rdata;
		av_rd <= 1'b0;
		av_wr <= 1'b0;
	endtask
	task automatic rchk(input logic [4:0] a, input logic [31:0] e);
		logic [31:0] r;
		bus_op(1'b0, a, 32'h0, r);
		chk("register", e, r);
	endtask
	task automatic wreg(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus_op(1'b1, a, d, r);
		if (a == REG_CTRL)
			ctrl_m = d[2:0];
		if (a == REG_COM0)
			com0_m = {d[11:3], 3'b0};
		if (a == REG_COM1)
			com1_m = {d[11:3], 3'b0};
	endtask
	function automatic logic fwd_exp(input logic m, input logic [19:0] a, input logic cl);
		if (cl)
			return 1'b0;
		if (m)
			return ctrl_m[2] && a >= MEMW_LO && a <= MEMW_HI;
		if (a >= OWN_LO && a <= OWN_HI)
			return 1'b0;
		if (ctrl_m[0] && a[15:3] == {4'h0, com0_m[11:3]})
			return 1'b0;
		if (ctrl_m[1] && a[15:3] == {4'h0, com1_m[11:3]})
			return 1'b0;
		return 1'b1;
	endfunction
	task automatic op(input logic m, w, wd, input logic [19:0] a, input logic [15:0] d,
			input logic cl);
		int n0;
		logic fe, hit, wio;
		logic [7:0] a0, a1;
		logic [15:0] mk, ex;
		@(posedge i_clock);
		n0 = nstb;
		h_mem <= m;
		h_wr <= w;
		h_wide <= wd;
		h_addr <= a;
		h_wdata <= d;
		h_claim <= cl;
		h_req <= 1'b1;
		do @(posedge i_clock); while (h_done !== 1'b1);
		fe = fwd_exp(m, a, cl);
		hit = fe && a[19:8] == (m ? 12'hd00 : 12'h003);
		wio = wd && !m;
		a0 = a[7:0];
		a1 = a0 + 8'h01;
		chk("forwarded", {31'h0, fe}, {31'h0, h_fwd});
		chk("strobes", !fe ? 0 : (wio && !(hit && we)) ? 2 : 1, nstb - n0);
		if (!fe && !w)
			chk("idle rdata", 32'h0000_ffff, {16'h0, h_rdata});
		mk = wio ? 16'hffff : 16'h00ff;
		ex = {ref_mem[a1], ref_mem[a0]};
		if (hit && !w)
			chk("rdata", {16'h0, ex & mk}, {16'h0, h_rdata & mk});
		if (hit && w) begin
			ref_mem[a0] = d[7:0];
			if (wio)
				ref_mem[a1] = d[15:8];
		end
		h_req <= 1'b0;
	endtask
	initial begin
		static logic [19:0] tb1 [10] = '{20'h0_0c80, 20'h0_0cbf, 20'h0_03f8, 20'h0_03ff, 20'h0_02f8,
			20'h0_02ff, 20'h0_0c7f, 20'h0_0cc0, 20'h0_03f6, 20'h0_0300};
		static logic [19:0] tb2 [5] = '{20'h0_02f8, 20'h0_0300, 20'h0_0306, 20'h0_0308, 20'h0_03f8};
		logic [31:0] r;
		for (int i = 0; i < 256; i++)
			ref_mem[i] = ~8'(i);
		repeat (16) @(posedge i_clock);
		i_arst_n <= 1'b1;
		rchk(REG_CTRL, {29'h0, CTRL_RST});
		rchk(REG_COM0, {20'h0, COM0_RST});
		rchk(REG_COM1, {20'h0, COM1_RST});
		rchk(REG_IRQEN, {22'h0, IRQEN_RST});
		rchk(5'h14, 32'h0000_0000);
		chk("static", {22'h0, aen, ref_n, dack_n, tc}, 32'h0000_01fe);
		$display("test reset done");
		foreach (tb1[i]) begin
			op(1'b0, 1'b0, 1'b0, tb1[i], 16'h0000, 1'b0);
			op(1'b0, 1'b1, 1'b0, tb1[i], 16'h005a, 1'b0);
		end
		op(1'b0, 1'b0, 1'b0, 20'h0_0310, 16'h0000, 1'b1);
		$display("test withheld ranges done");
		wreg(REG_COM0, 32'h0000_03ff);
		rchk(REG_COM0, 32'h0000_03f8);
		wreg(REG_COM1, 32'h0000_0300);
		wreg(REG_CTRL, 32'h0000_0002);
		foreach (tb2[i]) begin
			op(1'b0, 1'b1, 1'b0, tb2[i], 16'($random(seed)), 1'b0);
			op(1'b0, 1'b0, 1'b0, tb2[i], 16'h0000, 1'b0);
		end
		$display("test moved ranges done");
		for (int e = 0; e < 2; e++) begin
			wreg(REG_CTRL, {29'h0, e[0], 2'b11});
			op(1'b1, 1'b1, 1'b1, 20'hd_0020, 16'hc3a5 ^ 16'(e), 1'b0);
			op(1'b1, 1'b0, 1'b0, 20'hd_0020, 16'h0000, 1'b0);
			op(1'b1, 1'b0, 1'b0, 20'hc_ffff, 16'h0000, 1'b0);
			op(1'b1, 1'b0, 1'b0, 20'he_0000, 16'h0000, 1'b0);
		end
		$display("test memory window done");
		for (int i = 0; i < 4; i++) begin
			we <= i[0];
			waits <= i[1] ? 3'h7 : 3'h0;
			op(1'b0, 1'b1, 1'b1, 20'h0_0310, 16'h1234 + 16'(i), 1'b0);
			op(1'b0, 1'b0, 1'b1, 20'h0_0310, 16'h0000, 1'b0);
			rchk(REG_STAT, {14'h0, i[0], 17'h0_0000});
		end
		for (int i = 0; i < 40; i++) begin
			r = $random(seed);
			we <= r[20];
			waits <= r[23:21];
			op(r[24], r[25], r[26], {r[24] ? 12'hd00 : 12'h003, r[7:1], 1'b0}, r[15:0],
				r[29:27] == 3'h0);
		end
		$display("test width and random cycles done");
		irq_pin <= 10'h3ff;
		repeat (4) @(posedge i_clock);
		chk("irq", 32'h0000_0000, {22'h0, h_irq});
		wreg(REG_IRQEN, 32'h0000_02a5);
		for (int i = 0; i < 3; i++) begin
			irq_pin <= (i == 0) ? 10'h3ff : 10'($random(seed));
			repeat (4) @(posedge i_clock);
			chk("irq", {22'h0, irq_pin & 10'h2a5}, {22'h0, h_irq});
		end
		chk("static", {22'h0, aen, ref_n, dack_n, tc}, 32'h0000_01fe);
		$display("test interrupts done");
		finish_test();
	end
endmodule
